// >>> tb/eeprom_access_control_assertions.sv
// Purpose: port-level checks of the eeprom access controller
// Assumes: bound to the top module, sys_clk domain only
// Notes: engine state survives nrst, so mode hold uses porN
module eeprom_access_control_checker (
    // clock and resets
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic porN,
    // watched ports
    input wire eeprom_access_pkg::ioReq_t ioReq,
    input wire logic [7:0] ioRdData,
    input wire logic globalIrqEnable,
    input wire logic readyIrq,
    input wire logic cpuStall,
    input wire eeprom_access_pkg::memReq_t memReq
);
    default clocking @(posedge sys_clk);
    endclocking

    // register reads answer one cycle later
    chk_ctrl_rsvd: assert property (disable iff (!nrst) ioReq.rd && ioReq.addr == 6'h1f
        |=> ioRdData[7:6] == 2'b00 && !ioRdData[0]) else $error("ctrl spare bits set");
    chk_mode_read: assert property (disable iff (!nrst) ioReq.rd && ioReq.addr == 6'h1f
        |=> ioRdData[5:4] == $past(memReq.mode)) else $error("mode field misread");
    chk_irq_gate: assert property (disable iff (!nrst) readyIrq |-> globalIrqEnable)
        else $error("irq without global enable");
    chk_irq_busy: assert property (disable iff (!nrst) $rose(memReq.busy) |=> !readyIrq)
        else $error("irq while busy");
    chk_read_stall: assert property (disable iff (!nrst) memReq.rdEn
        |=> cpuStall [*4] ##1 !cpuStall) else $error("read stall length wrong");
    chk_prog_stall: assert property (disable iff (!nrst) memReq.progStart
        |-> cpuStall ##1 cpuStall ##1 !cpuStall) else $error("prog stall wrong");
    chk_start_busy: assert property (disable iff (!nrst) $rose(memReq.busy)
        |-> memReq.progStart) else $error("busy without start");
    chk_no_second: assert property (disable iff (!nrst) memReq.busy && $past(memReq.busy)
        |-> !memReq.progStart) else $error("second start while busy");
    chk_no_read: assert property (disable iff (!nrst) memReq.busy |-> !memReq.rdEn)
        else $error("read while busy");
    chk_addr_hold: assert property (disable iff (!nrst) memReq.busy && $past(memReq.busy)
        |-> $stable(memReq.addr)) else $error("address moved while busy");
    // mode must ride through a cpu reset, so only power-on disables it
    chk_mode_hold: assert property (disable iff (!porN) memReq.busy && $past(memReq.busy)
        |-> $stable(memReq.mode)) else $error("mode moved while busy");
endmodule

bind eeprom_access_control eeprom_access_control_checker chk_u (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .porN(porN),
    .ioReq(ioReq),
    .ioRdData(ioRdData),
    .globalIrqEnable(globalIrqEnable),
    .readyIrq(readyIrq),
    .cpuStall(cpuStall),
    .memReq(memReq)
);

// >>> tb/testbench.sv
// Purpose: directed bench of the eeprom access controller
// Assumes: short programming counts, 4 atomic and 2 split ticks
// Notes: rc ticks come only from the bench, so counts are exact
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0;
    logic ce = 1;
    logic nrst = 0;
    logic porN = 0;
    logic gie = 0;
    logic rcTick = 0;
    logic [7:0] memRdData = 8'h5a;
    eeprom_access_pkg::ioReq_t ioReq = '0;
    eeprom_access_pkg::memReq_t memReq;
    logic [7:0] ioRdData;
    logic readyIrq;
    logic cpuStall;
    int n_mismatch = 0;
    int check_count = 0;

    // 50 ns period
    initial forever #25 sys_clk = ~sys_clk;

    eeprom_access_control #(.TICKS_ATOMIC(4), .TICKS_SPLIT(2)) dut_u (
        .sys_clk(sys_clk),
        .ce(ce),
        .nrst(nrst),
        .porN(porN),
        .ioReq(ioReq),
        .ioRdData(ioRdData),
        .globalIrqEnable(gie),
        .readyIrq(readyIrq),
        .cpuStall(cpuStall),
        .rcTick(rcTick),
        .memRdData(memRdData),
        .memReq(memReq)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // one access; never issued while the cpu is stalled
    task automatic io(input logic w, input logic [5:0] a, input logic [7:0] d);
        int i;
        #1;
        for (i = 0; i < 9 && cpuStall !== 1'b0; i++)
            @(negedge sys_clk);
        if (i == 9)
        begin
            n_mismatch++;
            report_and_stop();
        end
        @(posedge sys_clk);
        ioReq <= '{w, !w, a, d};
        @(posedge sys_clk);
        ioReq <= '0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        io(0, a, 8'h00);
        #1 chk(ioRdData, e);
    endtask

    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            rcTick <= 1'b1;
            @(posedge sys_clk);
            rcTick <= 1'b0;
        end
    endtask

    // arm then start; reserved mode must not start; gie low, no flash write runs
    task automatic start(input logic [1:0] m);
        io(1, 6'h1f, 8'h04);
        io(1, 6'h1f, {2'b00, m, 4'h2});
        #1 chk(memReq.busy, m != 2'b11);
        chk(memReq.mode, m);
        chk(memReq.progStart, m != 2'b11);
        chk(cpuStall, m != 2'b11);
    endtask

    // busy holds until the last tick, then drops
    task automatic finish(input int n);
        int i;
        tick(n - 1);
        repeat (4) @(posedge sys_clk);
        #1 chk(memReq.busy, 1);
        tick(1);
        #1;
        for (i = 0; i < 9 && memReq.busy !== 1'b0; i++)
            @(negedge sys_clk);
        chk(memReq.busy, 0);
        if (i == 9)
            report_and_stop();
    endtask

    task automatic pulse_rst();
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic t_regs();
        rd(6'h1f, 8'h00);
        rd(6'h20, 8'h00);
        io(1, 6'h20, 8'ha5);
        rd(6'h20, 8'ha5);
        io(1, 6'h21, 8'h34);
        io(1, 6'h22, 8'hf2);
        #1 chk(memReq.addr, 16'h0234);
        io(1, 6'h1f, 8'h01);
        #1 chk(cpuStall, 1);
        rd(6'h20, 8'h5a);
        rd(6'h1f, 8'h00);
        // late start after the arm window closed, then arm and start in the same write
        io(1, 6'h1f, 8'h04);
        repeat (5) @(posedge sys_clk);
        io(1, 6'h1f, 8'h02);
        #1 chk(memReq.busy, 0);
        io(1, 6'h1f, 8'h06);
        #1 chk(memReq.busy, 0);
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic t_busy();
        io(1, 6'h20, 8'hc3);
        start(2'b10);
        chk(memReq.wrData, 8'hc3);
        io(1, 6'h1f, 8'h18);
        #1 chk(memReq.mode, 2'b10);
        io(1, 6'h21, 8'h00);
        #1 chk(memReq.addr, 16'h0234);
        io(1, 6'h1f, 8'h09);
        rd(6'h20, 8'hc3);
        io(1, 6'h1f, 8'h0c);
        io(1, 6'h1f, 8'h0a);
        gie <= 1'b1;
        #1 chk(readyIrq, 0);
        finish(2);
        chk(readyIrq, 1);
        rd(6'h1f, 8'h28);
        @(posedge sys_clk);
        gie <= 1'b0;
        #1 chk(readyIrq, 0);
    endtask

    task automatic t_reset();
        start(2'b01);
        // a low enable must freeze the tick count once the stall is over
        repeat (3) @(posedge sys_clk);
        ce <= 1'b0;
        tick(2);
        ce <= 1'b1;
        #1 chk(memReq.busy, 1);
        pulse_rst();
        #1 chk(memReq.mode, 2'b01);
        chk(memReq.busy, 1);
        finish(2);
        pulse_rst();
        #1 chk(memReq.mode, 2'b00);
    endtask

    initial
    begin
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        porN <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_regs();
        for (int m = 0; m < 4; m++)
        begin
            start(m[1:0]);
            if (m != 3)
                finish(m == 0 ? 4 : 2);
        end
        t_busy();
        t_reset();
        report_and_stop();
    end
endmodule

// >>> verilog/eeprom_access_control.sv
// Purpose: cpu i/o register front end of the data eeprom: data, control, address
// Assumes: eeprom array reads combinationally; cpu issues no i/o access while stalled
// Notes: one i/o access per cycle; reads answer one cycle later from a flop
`include "eeprom_access_control_consts.svh"

module eeprom_access_control #(
    parameter int unsigned TICKS_ATOMIC = `PROG_TICKS_ATOMIC,
    parameter int unsigned TICKS_SPLIT = `PROG_TICKS_SPLIT
) (
    // clock, enable, resets
    input wire logic sys_clk,
    input wire logic ce,
    input wire logic nrst,
    input wire logic porN,
    // cpu i/o register access
    input wire eeprom_access_pkg::ioReq_t ioReq,
    output logic [7:0] ioRdData,
    // cpu side status
    input wire logic globalIrqEnable,
    output logic readyIrq,
    output logic cpuStall,
    // rc oscillator tick
    input wire logic rcTick,
    // eeprom array
    input wire logic [7:0] memRdData,
    output eeprom_access_pkg::memReq_t memReq
);

    // reset synchroniser
    logic [1:0] rstPipe_r;
    logic rstN;

    // register side state and its next value
    eeprom_access_pkg::ctlState_t s_r;
    eeprom_access_pkg::ctlState_t s_nxt;

    // decoded control writes
    logic ctlWr;
    logic armed;
    logic progFire;
    logic rdFire;

    // engine status as seen from the register side
    logic engBusy;
    logic engDone;
    logic opBusy;
    eeprom_access_pkg::progMode_t engMode;
    logic [7:0] ctrlView;

    // reset release through two flops; first stage feeds only the second
    // async assert, sync release keeps the state flops clear of recovery trouble
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rstPipe_r <= 2'h0;
        end
        else if (ce)
        begin
            rstPipe_r <= {rstPipe_r[0], 1'b1};
        end
    end

    assign rstN = rstPipe_r[1];

    // decode of the control write and the two strobes
    always_comb
    begin
        ctlWr = ioReq.wr && (ioReq.addr == `NV_CTRL_ADDR);
        armed = (s_r.armCnt != `CNT3_ZERO);
        // arm must already be set; same-write arm does not count
        // reserved mode fires nothing: no stall, no start pulse, arm kept
        // busy covers the done cycle too, so a start there is refused
        progFire = ctlWr && ioReq.data[`CTRL_BUSY_BIT] && armed && !opBusy &&
            (ioReq.data[`CTRL_MODE_HI_BIT:`CTRL_MODE_LO_BIT] != 2'h3); // R3 R8 R20
        // a read asked in the same write as a start is dropped
        rdFire = ctlWr && ioReq.data[`CTRL_READ_BIT] && !opBusy && !progFire; // R14 R20
    end

    // control register as software sees it
    always_comb
    begin
        ctrlView = 8'h00; // R2
        ctrlView[`CTRL_MODE_HI_BIT:`CTRL_MODE_LO_BIT] = engMode;
        ctrlView[`CTRL_RIE_BIT] = s_r.rie;
        ctrlView[`CTRL_ARM_BIT] = armed;
        // strobe bit 0 always reads zero; busy is the shared flag
        ctrlView[`CTRL_BUSY_BIT] = opBusy;
    end

    // next state of the register side
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.progStart = 1'b0;

        // arm window: counts down, consumed by a start
        // the window is counted on enabled edges only
        if (armed)
        begin
            s_nxt.armCnt = s_r.armCnt - 3'h1; // R7
        end
        // rewriting a set arm bit does not extend the window
        if (ctlWr && ioReq.data[`CTRL_ARM_BIT] && !armed)
        begin
            s_nxt.armCnt = `ARM_WINDOW_CYCLES; // R7
        end
        if (progFire)
        begin
            s_nxt.armCnt = `CNT3_ZERO;
            s_nxt.progData = s_r.dataReg; // R1
            s_nxt.progStart = 1'b1;
        end

        if (ctlWr)
        begin
            s_nxt.rie = ioReq.data[`CTRL_RIE_BIT];
        end

        // data register: software write or fetched byte
        if (ioReq.wr && ioReq.addr == `NV_DATA_ADDR)
        begin
            s_nxt.dataReg = ioReq.data; // R1
        end
        if (rdFire)
        begin
            s_nxt.dataReg = memRdData; // R13
        end

        // address register frozen while programming
        // the array keeps this address for the whole operation unless a cpu reset clears it
        if (ioReq.wr && !opBusy && ioReq.addr == `NV_LOC_LO_ADDR)
        begin
            s_nxt.locReg[7:0] = ioReq.data; // R14
        end
        if (ioReq.wr && !opBusy && ioReq.addr == `NV_LOC_HI_ADDR)
        begin
            s_nxt.locReg[11:8] = ioReq.data[3:0]; // R18
        end

        // cpu stall counter
        // a start and a read never fire together, so their loads never clash
        if (s_r.stallCnt != `CNT3_ZERO)
        begin
            s_nxt.stallCnt = s_r.stallCnt - 3'h1;
        end
        if (progFire)
        begin
            s_nxt.stallCnt = `STALL_PROG_CYCLES; // R12
        end
        if (rdFire)
        begin
            s_nxt.stallCnt = `STALL_READ_CYCLES; // R13
        end

        // read data answers from a flop on the next cycle
        // unmapped addresses answer zero rather than stale data
        if (ioReq.rd)
        begin
            case (ioReq.addr)
                `NV_CTRL_ADDR: s_nxt.rdData = ctrlView;
                `NV_DATA_ADDR: s_nxt.rdData = s_r.dataReg;
                `NV_LOC_LO_ADDR: s_nxt.rdData = s_r.locReg[7:0];
                `NV_LOC_HI_ADDR: s_nxt.rdData = {4'h0, s_r.locReg[11:8]}; // R18
                default: s_nxt.rdData = 8'h00;
            endcase
        end
    end

    // register side state, cleared by the synchronised cpu reset
    // engine flops live in the timer, so this reset cannot cut an operation short
    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            s_r <= '0;
        end
        else if (ce)
        begin
            s_r <= s_nxt;
        end
    end

    // engine keeps running through a cpu reset
    // mode writes are refused in the done cycle too, while busy still reads one
    nv_prog_timer #(
        .TICKS_ATOMIC(TICKS_ATOMIC),
        .TICKS_SPLIT(TICKS_SPLIT)
    ) progTimer (
        .clk(sys_clk),
        .ce(ce),
        .porN(porN),
        .cpuRstActive(!rstN),
        .start(progFire),
        .modeWrEn(ctlWr && !opBusy), // R4
        .modeWrVal(eeprom_access_pkg::progMode_t'(
            ioReq.data[`CTRL_MODE_HI_BIT:`CTRL_MODE_LO_BIT])),
        .rcTick(rcTick),
        .busy(engBusy),
        .mode(engMode),
        .done(engDone)
    );

    // done cycle counts as busy so status, irq and array port agree
    assign opBusy = engBusy || engDone; // R11

    // level request, held while the engine is idle and both rie and the global enable are set
    assign readyIrq = s_r.rie && globalIrqEnable && !opBusy; // R6
    assign cpuStall = (s_r.stallCnt != `CNT3_ZERO); // R12 R13
    assign ioRdData = s_r.rdData;

    // array port; address writes are blocked during programming, but a cpu reset clears the address
    always_comb
    begin
        memReq.rdEn = rdFire; // R13
        memReq.progStart = s_r.progStart;
        memReq.mode = engMode;
        memReq.addr = s_r.locReg;
        memReq.wrData = s_r.progData;
        // busy reaches the array through the one shared flag
        memReq.busy = opBusy;
    end

endmodule

// >>> verilog/eeprom_access_control_consts.svh
// Purpose: offsets, field positions, reset values and counts of the eeprom access controller
// Assumes: registers sit in the 6-bit cpu i/o address space
// Notes: included by bare name, definitions only
// Function
// R1 - data register feeds writes, receives reads
// R2 - control bits 7:6 read zero
// R3 - mode field picks erase+write, erase, write
// R4 - mode writes ignored while programming
// R5 - reset clears mode unless programming
// R6 - ready irq while idle, enabled, global enabled
// R7 - arm bit self-clears after four cycles
// R8 - busy strobe starts only while armed
// R9 - software follows the armed write order
// R10 - software avoids eeprom write during flash write
// R11 - hardware clears busy when time elapses
// R12 - programming start stalls cpu two cycles
// R13 - read strobe loads data, stalls four
// R14 - no read, no address change while busy
// R15 - programming timed by rc oscillator ticks
// R16 - software keeps interrupts off during sequence
// R17 - software polls busy before reading
// R18 - 12-bit address, upper bits read zero
// R19 - programming survives a cpu reset
// R20 - no second operation while one runs
`ifndef EEPROM_ACCESS_CONTROL_CONSTS_SVH
`define EEPROM_ACCESS_CONTROL_CONSTS_SVH

// i/o addresses
`define NV_CTRL_ADDR 6'h1f
`define NV_DATA_ADDR 6'h20
`define NV_LOC_LO_ADDR 6'h21
`define NV_LOC_HI_ADDR 6'h22

// control register field positions
`define CTRL_READ_BIT 0
`define CTRL_BUSY_BIT 1
`define CTRL_ARM_BIT 2
`define CTRL_RIE_BIT 3
`define CTRL_MODE_LO_BIT 4
`define CTRL_MODE_HI_BIT 5

// reset values
`define DATA_RST 8'h00
`define LOC_RST 12'h000
`define CNT3_ZERO 3'h0

// cycle counts on sys_clk
`define ARM_WINDOW_CYCLES 3'h4
`define STALL_PROG_CYCLES 3'h2
`define STALL_READ_CYCLES 3'h4

// programming length in rc oscillator ticks
`define PROG_TICKS_ATOMIC 26368
`define PROG_TICKS_SPLIT 13959

`endif

// >>> verilog/eeprom_access_pkg.sv
// Purpose: types shared by the eeprom access controller and its programming timer
// Assumes: nothing beyond the constants header
// Notes: state structs hold all flops of each module except the reset synchroniser
package eeprom_access_pkg;

    // programming action selected by the mode field
    typedef enum logic [1:0]
    {
        PM_ATOMIC = 2'b00,
        PM_ERASE = 2'b01,
        PM_WRITE = 2'b10,
        PM_RSVD = 2'b11
    } progMode_t;

    typedef enum logic
    {
        ENG_IDLE = 1'b0,
        ENG_PROG = 1'b1
    } engPhase_t;

    // cpu i/o register access, one request per cycle
    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] data;
    } ioReq_t;

    // port toward the eeprom array
    typedef struct packed
    {
        logic rdEn;
        logic progStart;
        progMode_t mode;
        logic [11:0] addr;
        logic [7:0] wrData;
        logic busy;
    } memReq_t;

    typedef struct packed
    {
        engPhase_t phase;
        progMode_t mode;
        logic [14:0] ticks;
        logic done;
    } engState_t;

    typedef struct packed
    {
        logic [7:0] dataReg;
        logic [11:0] locReg;
        logic rie;
        logic [2:0] armCnt;
        logic [2:0] stallCnt;
        logic [7:0] rdData;
        logic [7:0] progData;
        logic progStart;
    } ctlState_t;

endpackage

// >>> verilog/nv_prog_timer.sv
// Purpose: programming engine, holds mode field and times an operation in rc ticks
// Assumes: rcTick is a one-cycle pulse per rc oscillator period, synchronous to clk
// Notes: reset only by the power-on reset so a cpu reset never aborts programming
`include "eeprom_access_control_consts.svh"

module nv_prog_timer #(
    parameter int unsigned TICKS_ATOMIC = `PROG_TICKS_ATOMIC,
    parameter int unsigned TICKS_SPLIT = `PROG_TICKS_SPLIT
) (
    // clock, enable, power-on reset
    input wire logic clk,
    input wire logic ce,
    input wire logic porN,
    // requests from the register side
    input wire logic cpuRstActive,
    input wire logic start,
    input wire logic modeWrEn,
    input wire eeprom_access_pkg::progMode_t modeWrVal,
    input wire logic rcTick,
    // status
    output logic busy,
    output eeprom_access_pkg::progMode_t mode,
    output logic done
);

    localparam logic [14:0] LOAD_ATOMIC = 15'(TICKS_ATOMIC - 1);
    localparam logic [14:0] LOAD_SPLIT = 15'(TICKS_SPLIT - 1);

    eeprom_access_pkg::engState_t s_r;
    eeprom_access_pkg::engState_t s_nxt;
    eeprom_access_pkg::progMode_t useMode;

    // next state: mode field, start, tick countdown
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        useMode = modeWrEn ? modeWrVal : s_r.mode;
        case (s_r.phase)
            eeprom_access_pkg::ENG_IDLE:
            begin
                if (cpuRstActive)
                begin
                    s_nxt.mode = eeprom_access_pkg::PM_ATOMIC; // R5
                end
                else if (modeWrEn)
                begin
                    s_nxt.mode = modeWrVal; // R3
                end
                // reserved mode starts nothing
                if (start && !cpuRstActive && useMode != eeprom_access_pkg::PM_RSVD)
                begin
                    s_nxt.phase = eeprom_access_pkg::ENG_PROG;
                    s_nxt.ticks = (useMode == eeprom_access_pkg::PM_ATOMIC) ?
                        LOAD_ATOMIC : LOAD_SPLIT; // R3
                end
            end
            // mode writes and resets fall through untouched here
            eeprom_access_pkg::ENG_PROG:
            begin
                if (rcTick) // R15
                begin
                    if (s_r.ticks == 15'h0000)
                    begin
                        s_nxt.phase = eeprom_access_pkg::ENG_IDLE; // R11
                        s_nxt.done = 1'b1;
                    end
                    else
                    begin
                        s_nxt.ticks = s_r.ticks - 15'h0001;
                    end
                end
            end // R4 R19
            default:
            begin
                s_nxt.phase = eeprom_access_pkg::ENG_IDLE;
            end
        endcase
    end

    // only power-on reset clears the engine
    always_ff @(posedge clk or negedge porN)
    begin
        if (!porN)
        begin
            s_r <= '0;
        end
        else if (ce)
        begin
            s_r <= s_nxt;
        end
    end

    assign busy = (s_r.phase == eeprom_access_pkg::ENG_PROG);
    assign mode = s_r.mode;
    assign done = s_r.done;

endmodule
